// *** core/pie_irq_ctrl.sv ***
// Purpose: Core and peripheral interrupt flag, enable and request logic.
// Assumes: Peripheral flags are set by one-cycle pulses from their modules.
// Notes: Flags are set regardless of enables; set wins over a clear.
`timescale 1ns/1ps
module pie_irq_ctrl
  import pie_pkg::*;
#(
  parameter int PORT_A_W = 8,
  parameter int PORT_B_W = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [PIE_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic ext_irq_pin,
  input wire logic [PORT_A_W-1:0] port_a_pins,
  input wire logic [PORT_B_W-1:0] port_b_pins,
  // Sources
  input wire logic t0_tick,
  input wire logic [7:0] periph_evt,
  // Requests
  output logic cpu_irq_req,
  output logic evt_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] core_irq_control_r;
  logic [7:0] core_irq_control_nxt;
  logic [7:0] peripheral_irq_enable_r;
  logic [7:0] periph_flag_r;
  logic [7:0] periph_flag_nxt;
  logic [PIE_NUM_EV-1:0] evt_status_r;
  logic [PIE_NUM_EV-1:0] evt_status_nxt;
  logic [PIE_NUM_EV-1:0] evt_mask_r;
  logic [PORT_A_W+PORT_B_W-1:0] port_last_r;
  logic ext_last_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Pin synchronisers and timer
  // ----------------------------------------------------------------
  logic [PORT_A_W+PORT_B_W:0] pins_sync;
  logic [7:0] t0_count;
  logic t0_ovf;

  pie_pin_sync #(
    .WIDTH(PORT_A_W + PORT_B_W + 1)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .async_in({ext_irq_pin, port_b_pins, port_a_pins}),
    .sync_out(pins_sync)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_core = reg_wr && (reg_addr == PIE_OFS_CORE_CTRL);
  wire wr_pen = reg_wr && (reg_addr == PIE_OFS_PERIPH_EN);
  wire wr_pflag = reg_wr && (reg_addr == PIE_OFS_PERIPH_FLAG);
  wire wr_t0 = reg_wr && (reg_addr == PIE_OFS_T0_COUNT);
  wire wr_evst = reg_wr && (reg_addr == PIE_OFS_EVT_STATUS);
  wire wr_evmk = reg_wr && (reg_addr == PIE_OFS_EVT_MASK);

  pie_t0_counter #(
    .WIDTH(8)
  ) u_t0 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .tick(t0_tick),
    .load(wr_t0),
    .load_val(reg_wdata),
    .t0_count(t0_count),
    .overflow(t0_ovf)
  );

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  wire [PORT_A_W+PORT_B_W-1:0] port_now = pins_sync[PORT_A_W+PORT_B_W-1:0];
  wire ext_now = pins_sync[PORT_A_W+PORT_B_W];
  // Rising edge only; edge select lives in a register outside this block.
  wire ext_evt = ext_now && !ext_last_r;
  wire port_evt = |(port_now ^ port_last_r);

  // Hardware sets take priority over software writes in the same cycle.
  wire [7:0] core_set = {5'b00000, t0_ovf, ext_evt, port_evt};
  always_comb begin
    core_irq_control_nxt = core_irq_control_r;
    if (wr_core) begin
      core_irq_control_nxt = reg_wdata;
    end
    core_irq_control_nxt = core_irq_control_nxt | core_set;
  end

  always_comb begin
    periph_flag_nxt = periph_flag_r;
    if (wr_pflag) begin
      periph_flag_nxt = reg_wdata;
    end
    periph_flag_nxt = periph_flag_nxt | periph_evt;
  end

  // ----------------------------------------------------------------
  // Request combination
  // ----------------------------------------------------------------
  wire [7:0] periph_act = periph_flag_r & peripheral_irq_enable_r;
  wire periph_req = (|periph_act) && core_irq_control_r[PIE_CC_PGATE];
  wire core_req = (core_irq_control_r[PIE_CC_T0IE] && core_irq_control_r[PIE_CC_T0IF])
    || (core_irq_control_r[PIE_CC_EXTIE] && core_irq_control_r[PIE_CC_EXTIF])
    || (core_irq_control_r[PIE_CC_PCIE] && core_irq_control_r[PIE_CC_PCIF]);
  wire req_nxt = core_irq_control_r[PIE_CC_GLOBAL_EN] && (periph_req || core_req);

  wire [PIE_NUM_EV-1:0] evt_raw = {|periph_evt, port_evt, ext_evt, t0_ovf};
  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_evst) begin
      evt_status_nxt = evt_status_r & ~reg_wdata[PIE_NUM_EV-1:0];
    end
    evt_status_nxt = evt_status_nxt | evt_raw;
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_addr)
      PIE_OFS_CORE_CTRL: rdata_nxt = core_irq_control_r;
      PIE_OFS_PERIPH_EN: rdata_nxt = peripheral_irq_enable_r;
      PIE_OFS_PERIPH_FLAG: rdata_nxt = periph_flag_r;
      PIE_OFS_T0_COUNT: rdata_nxt = t0_count;
      PIE_OFS_EVT_STATUS: rdata_nxt = {4'h0, evt_status_r};
      PIE_OFS_EVT_MASK: rdata_nxt = {4'h0, evt_mask_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      core_irq_control_r <= PIE_RST_CORE_CTRL;
      periph_flag_r <= PIE_RST_PERIPH_FLAG;
      evt_status_r <= PIE_RST_EVT[PIE_NUM_EV-1:0];
    end else begin
      core_irq_control_r <= core_irq_control_nxt;
      periph_flag_r <= periph_flag_nxt;
      evt_status_r <= evt_status_nxt;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      peripheral_irq_enable_r <= PIE_RST_PERIPH_EN;
      evt_mask_r <= PIE_RST_EVT[PIE_NUM_EV-1:0];
    end else begin
      if (wr_pen) begin
        peripheral_irq_enable_r <= reg_wdata;
      end
      if (wr_evmk) begin
        evt_mask_r <= reg_wdata[PIE_NUM_EV-1:0];
      end
    end
  end

  // Last-seen pin values follow the synchronised pins every cycle.
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      port_last_r <= '0;
      ext_last_r <= 1'b0;
    end else begin
      port_last_r <= port_now;
      ext_last_r <= ext_now;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
      cpu_irq_req <= 1'b0;
      evt_irq <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rdata_nxt : 8'h00;
      cpu_irq_req <= req_nxt;
      evt_irq <= |(evt_status_nxt & evt_mask_r);
    end
  end

endmodule : pie_irq_ctrl

// *** core/pie_pin_sync.sv ***
// Purpose: Three-stage synchroniser for pin inputs with a stable output.
// Assumes: Inputs are asynchronous to clk_sys.
// Notes: The output changes only once stages two and three agree.
`timescale 1ns/1ps
module pie_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] out_nxt;

  assign agree = ~(s2_r ^ s3_r);
  assign out_nxt = (agree & s3_r) | (~agree & sync_out);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      sync_out <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      sync_out <= out_nxt;
    end
  end

endmodule : pie_pin_sync

// *** core/pie_pkg.sv ***
// Purpose: Constants shared by the peripheral interrupt enable and flag logic.
// Assumes: Registers are at most eight bits wide and sit in the low bits of the read data.
// Notes: Offsets are register indices on the plain register port.
package pie_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int PIE_ADDR_W = 4;
  localparam logic [3:0] PIE_OFS_CORE_CTRL = 4'h0;
  localparam logic [3:0] PIE_OFS_PERIPH_EN = 4'h1;
  localparam logic [3:0] PIE_OFS_PERIPH_FLAG = 4'h2;
  localparam logic [3:0] PIE_OFS_T0_COUNT = 4'h3;
  localparam logic [3:0] PIE_OFS_EVT_STATUS = 4'h4;
  localparam logic [3:0] PIE_OFS_EVT_MASK = 4'h5;

  // ----------------------------------------------------------------
  // Core interrupt control fields
  // ----------------------------------------------------------------
  localparam int PIE_CC_GLOBAL_EN = 7;
  localparam int PIE_CC_PGATE = 6;
  localparam int PIE_CC_T0IE = 5;
  localparam int PIE_CC_EXTIE = 4;
  localparam int PIE_CC_PCIE = 3;
  localparam int PIE_CC_T0IF = 2;
  localparam int PIE_CC_EXTIF = 1;
  localparam int PIE_CC_PCIF = 0;

  // ----------------------------------------------------------------
  // Peripheral enable fields
  // ----------------------------------------------------------------
  localparam int PIE_PE_T1G = 7;
  localparam int PIE_PE_ADC = 6;
  localparam int PIE_PE_RX = 5;
  localparam int PIE_PE_TX = 4;
  localparam int PIE_PE_SSP = 3;
  localparam int PIE_PE_CCP = 2;
  localparam int PIE_PE_T2 = 1;
  localparam int PIE_PE_T1OV = 0;

  // ----------------------------------------------------------------
  // Reset values and event status layout
  // ----------------------------------------------------------------
  localparam logic [7:0] PIE_RST_CORE_CTRL = 8'h00;
  localparam logic [7:0] PIE_RST_PERIPH_EN = 8'h00;
  localparam logic [7:0] PIE_RST_PERIPH_FLAG = 8'h00;
  localparam logic [7:0] PIE_RST_T0_COUNT = 8'h00;
  localparam logic [7:0] PIE_RST_EVT = 8'h00;
  localparam int PIE_EV_T0 = 0;
  localparam int PIE_EV_EXT = 1;
  localparam int PIE_EV_PC = 2;
  localparam int PIE_EV_PERIPH = 3;
  localparam int PIE_SYNC_W = 3;
  localparam int PIE_NUM_EV = 4;

endpackage : pie_pkg

// *** core/pie_t0_counter.sv ***
// Purpose: Timer-0 count register with overflow pulse.
// Assumes: Counting is enabled by a tick from the prescaler outside.
// Notes: Reset leaves the count untouched, so software must load it first.
`timescale 1ns/1ps
module pie_t0_counter #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  // Status
  output logic [WIDTH-1:0] t0_count,
  output logic overflow
);

  logic [WIDTH-1:0] cnt_nxt;
  logic wrap;

  assign wrap = tick && !load && (t0_count == {WIDTH{1'b1}});
  assign cnt_nxt = load ? load_val : (tick ? t0_count + 1'b1 : t0_count);

  // The count has no reset on purpose: its value survives a reset.
  always_ff @(posedge clk_sys) begin
    t0_count <= cnt_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      overflow <= 1'b0;
    end else begin
      overflow <= wrap;
    end
  end

endmodule : pie_t0_counter

// *** test/pie_irq_checker.sv ***
// Purpose: Port-level assertions for the interrupt controller.
// Assumes: Enables are mirrored here from register port writes.
// Notes: Flags are not mirrored, so only blocking cases are exact.
`timescale 1ns/1ps
module pie_irq_checker
  import pie_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [PIE_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Sources and request
  input wire logic [7:0] periph_evt,
  input wire logic cpu_irq_req
);
  logic [7:0] cc_r;
  logic [7:0] pe_r;
  wire quiet = !cc_r[6] && cc_r[5:3] == 3'h0;
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cc_r <= 8'h00;
      pe_r <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == PIE_OFS_CORE_CTRL) cc_r <= reg_wdata;
      if (reg_addr == PIE_OFS_PERIPH_EN) pe_r <= reg_wdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence wr_s(a);
    reg_wr && reg_addr == a;
  endsequence
  sequence rd_s(a);
    reg_rd && reg_addr == a;
  endsequence
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  rst_quiet_a: assert property ($rose(nrst) |-> !cpu_irq_req && reg_rdata == 8'h00)
    else $error("outputs not quiet after reset");
  pe_back_a: assert property (wr_s(PIE_OFS_PERIPH_EN) ##1 !reg_wr ##1
    rd_s(PIE_OFS_PERIPH_EN) |=> reg_rdata == $past(reg_wdata, 3))
    else $error("enable readback wrong");
  cc_back_a: assert property (wr_s(PIE_OFS_CORE_CTRL) ##1 !reg_wr ##1
    rd_s(PIE_OFS_CORE_CTRL) |=> reg_rdata[7:3] == $past(reg_wdata[7:3], 3))
    else $error("control readback wrong");
  unmapped_rd_a: assert property (reg_rd && reg_addr > PIE_OFS_EVT_MASK |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  gie_block_a: assert property (!cc_r[7] && !$past(cc_r[7]) |-> !cpu_irq_req)
    else $error("request without global enable");
  pgate_block_a: assert property (quiet && $past(quiet) |-> !cpu_irq_req)
    else $error("request without gate");
  periph_req_a: assert property (cc_r[7] && cc_r[6] && !reg_wr &&
    (periph_evt & pe_r) != 8'h00 |-> ##2 cpu_irq_req)
    else $error("enabled event gave no request");
endmodule : pie_irq_checker

bind pie_irq_ctrl pie_irq_checker u_chk (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .periph_evt(periph_evt),
  .cpu_irq_req(cpu_irq_req)
);

// *** test/pie_periph_model.sv ***
// Purpose: Behavioural peripheral modules raising event pulses.
// Assumes: fire is driven just after a rising edge.
// Notes: One process drives the events, so each pulse lasts as long as fire is held high.
`timescale 1ns/1ps
module pie_periph_model (
  // Clock
  input wire logic clk_sys,
  // Command
  input wire logic fire,
  input wire logic [2:0] idx,
  // Events
  output logic [7:0] periph_evt
);
  always @(posedge clk_sys) begin
    periph_evt <= fire ? (8'h01 << idx) : 8'h00;
  end
endmodule : pie_periph_model

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: Pins are quiet through the first reset.
// Notes: Pin flags are checked well after the synchroniser delay.
`timescale 1ns/1ps
module tb_top
  import pie_pkg::*;
;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [PIE_ADDR_W-1:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_irq_pin = 1'b0;
  logic [7:0] port_a_pins = 8'h00;
  logic [7:0] port_b_pins = 8'h00;
  logic t0_tick = 1'b0;
  logic fire = 1'b0;
  logic [2:0] idx = 3'h0;
  wire logic [7:0] reg_rdata;
  wire logic [7:0] periph_evt;
  wire logic cpu_irq_req;
  wire logic evt_irq;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  always #5 clk_sys = ~clk_sys;
  pie_periph_model u_src (.clk_sys(clk_sys), .fire(fire), .idx(idx), .periph_evt(periph_evt));
  pie_irq_ctrl u_dut (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ext_irq_pin(ext_irq_pin),
    .port_a_pins(port_a_pins),
    .port_b_pins(port_b_pins),
    .t0_tick(t0_tick),
    .periph_evt(periph_evt),
    .cpu_irq_req(cpu_irq_req),
    .evt_irq(evt_irq)
  );
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task rq(input logic e);
    chk({7'h00, cpu_irq_req}, {7'h00, e});
  endtask : rq
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wt
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task pulse(input logic [2:0] i);
    @(posedge clk_sys);
    fire <= 1'b1;
    idx <= i;
    @(posedge clk_sys);
    fire <= 1'b0;
  endtask : pulse
  task complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // A hang counts as a mismatch and still reaches the verdict.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(PIE_OFS_CORE_CTRL, 8'h00);
    rd(PIE_OFS_PERIPH_EN, 8'h00);
    rd(PIE_OFS_PERIPH_FLAG, 8'h00);
    rd(PIE_OFS_EVT_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    wr(4'hF, 8'hFF);
    rd(PIE_OFS_PERIPH_EN, 8'h00);
    wr(PIE_OFS_PERIPH_EN, 8'hA5);
    rd(PIE_OFS_PERIPH_EN, 8'hA5);
    wr(PIE_OFS_CORE_CTRL, 8'hC0);
    for (int i = 0; i < 8; i++) begin
      wr(PIE_OFS_PERIPH_EN, 8'h01 << i);
      pulse(i[2:0]);
      wt(3);
      rq(1'b1);
      wr(PIE_OFS_PERIPH_FLAG, 8'h00);
      wt(2);
      rq(1'b0);
      pulse(i[2:0] + 3'h1);
      wt(3);
      rq(1'b0);
      rd(PIE_OFS_PERIPH_FLAG, 8'h01 << ((i + 1) % 8));
      wr(PIE_OFS_PERIPH_FLAG, 8'h00);
    end
    wr(PIE_OFS_CORE_CTRL, 8'h80);
    wr(PIE_OFS_PERIPH_EN, 8'hFF);
    pulse(3'h5);
    wt(3);
    rq(1'b0);
    wr(PIE_OFS_CORE_CTRL, 8'h40);
    wt(2);
    rq(1'b0);
    wr(PIE_OFS_CORE_CTRL, 8'hC0);
    wt(2);
    rq(1'b1);
    wr(PIE_OFS_PERIPH_FLAG, 8'h00);
    wr(PIE_OFS_CORE_CTRL, 8'h00);
    rd(PIE_OFS_CORE_CTRL, 8'h00);
    ext_irq_pin <= 1'b1;
    wt(10);
    rd(PIE_OFS_CORE_CTRL, 8'h02);
    wt(20);
    rd(PIE_OFS_CORE_CTRL, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wr(PIE_OFS_CORE_CTRL, 8'h00);
      port_a_pins[6] <= k[0];
      port_b_pins[3] <= 1'b1;
      wt(10);
      rd(PIE_OFS_CORE_CTRL, 8'h01);
    end
    wr(PIE_OFS_T0_COUNT, 8'hFE);
    @(posedge clk_sys);
    t0_tick <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t0_tick <= 1'b0;
    wt(4);
    rd(PIE_OFS_CORE_CTRL, 8'h05);
    wr(PIE_OFS_EVT_MASK, 8'h00);
    wt(2);
    chk({7'h00, evt_irq}, 8'h00);
    wr(PIE_OFS_EVT_MASK, 8'hFF);
    wt(2);
    chk({7'h00, evt_irq}, 8'h01);
    wr(PIE_OFS_EVT_STATUS, 8'h0F);
    wt(2);
    chk({7'h00, evt_irq}, 8'h00);
    wr(PIE_OFS_CORE_CTRL, 8'hA4);
    rd(PIE_OFS_CORE_CTRL, 8'hA4);
    rq(1'b1);
    wr(PIE_OFS_CORE_CTRL, 8'h24);
    wt(2);
    rq(1'b0);
    wr(PIE_OFS_CORE_CTRL, 8'h00);
    rd(PIE_OFS_CORE_CTRL, 8'h00);
    // A second reset must clear the enables but leave the timer count alone.
    wr(PIE_OFS_T0_COUNT, 8'h5A);
    nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(PIE_OFS_T0_COUNT, 8'h5A);
    rd(PIE_OFS_PERIPH_EN, 8'h00);
    complete_run;
  end
endmodule : tb_top
